// ---- adc_conv_model.sv ----
// Converter model that reports finished conversions to the FIFO
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the bench
  input wire logic req,
  input wire logic [11:0] val,
  input wire logic ghost,
  // Conversion result toward the FIFO
  output logic done,
  output logic [11:0] data,
  output logic discard
);
  // One done pulse per request; data is scrambled between pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      data <= 12'h000;
      discard <= 1'b0;
    end else begin
      done <= req;
      data <= req ? val : ~data;
      discard <= req ? ghost : ~discard;
    end
  end
endmodule : adc_conv_model
`default_nettype wire

// ---- adc_fifo_pkg.sv ----
// Constants shared by the conversion-result FIFO readout
package adc_fifo_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFS_RESULT_POP = 8'h16;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_CONTROL = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  // Status register fields
  localparam int STAT_PRESENT_N_BIT = 0;
  localparam int STAT_HALF_N_BIT = 1;
  // Control register fields
  localparam int CTRL_POLARITY_BIT = 0;
  // Interrupt status fields
  localparam int IRQ_PUSH_BIT = 0;
  localparam int IRQ_HALF_BIT = 1;
  localparam int IRQ_OVERFLOW_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;
  // Widths and default depth
  localparam int RESULT_WIDTH = 12;
  localparam int REG_WIDTH = 16;
  localparam int FIFO_DEPTH_DEFAULT = 16;
endpackage : adc_fifo_pkg

// ---- adc_fifo_store.sv ----
// Storage array and pointers for conversion results
`timescale 1ns/1ps
`default_nettype none
module adc_fifo_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Push side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // Pop side
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  // Occupancy
  output logic [CW-1:0] count,
  output logic full,
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic do_push;
  logic do_pop;

  // Full drops pushes, empty ignores pops
  assign do_push = push && (count_q != CW'(DEPTH));
  assign do_pop = pop && (count_q != '0);
  assign count = count_q;
  assign full = (count_q == CW'(DEPTH));
  assign empty = (count_q == '0);
  assign head_data = mem[rd_ptr_q];

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : next_ptr

  // Storage write
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= push_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (do_pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : adc_fifo_store
`default_nettype wire

// ---- adc_result_fifo_readout.sv ----
// Conversion-result FIFO with register readout and interrupt
`timescale 1ns/1ps
`default_nettype none
module adc_result_fifo_readout #(
  parameter int DEPTH = adc_fifo_pkg::FIFO_DEPTH_DEFAULT
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Converter side, same clock
  input wire logic CONV_DONE,
  input wire logic [11:0] CONV_DATA,
  input wire logic DISCARD_RESULT_FLAG,
  // Interrupt and flags
  output logic IRQ,
  output logic RESULTS_PRESENT_N,
  output logic HALF_CAPACITY_N
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int W = adc_fifo_pkg::REG_WIDTH;
  localparam int IW = adc_fifo_pkg::IRQ_WIDTH;

  logic rst_meta_q;
  logic rst_sync_q;
  logic [W-1:0] control_q;
  logic [IW-1:0] irq_stat_q;
  logic [IW-1:0] irq_mask_q;
  logic [IW-1:0] irq_set;
  logic [W-1:0] rdata_q;
  logic irq_q;
  logic present_n_q;
  logic half_n_q;
  logic half_prev_q;
  logic push;
  logic pop;
  logic [11:0] head_data;
  logic [CW-1:0] count;
  logic full;
  logic empty;
  logic at_half;
  logic [W-1:0] fmt_result;
  logic [W-1:0] status_word;

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Push and pop requests
  assign push = CONV_DONE && !DISCARD_RESULT_FLAG;
  assign pop = REG_RD && hit(REG_ADDR, adc_fifo_pkg::OFS_RESULT_POP);

  // Result storage
  adc_fifo_store #(
    .WIDTH(adc_fifo_pkg::RESULT_WIDTH),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_store (
    .clk(CLK_SYS),
    .rst_n(rst_sync_q),
    .push(push),
    .push_data(CONV_DATA),
    .pop(pop),
    .head_data(head_data),
    .count(count),
    .full(full),
    .empty(empty)
  );

  // Half-capacity threshold
  assign at_half = (count >= CW'(DEPTH / 2));

  // Result formatting by polarity bit
  always_comb begin
    if (control_q[adc_fifo_pkg::CTRL_POLARITY_BIT]) begin
      fmt_result = {{5{~head_data[11]}}, head_data[10:0]};
    end else begin
      fmt_result = {4'h0, head_data};
    end
  end

  // Status word, present bit high when results are held, half bit low at half capacity
  always_comb begin
    status_word = '0;
    status_word[adc_fifo_pkg::STAT_PRESENT_N_BIT] = !empty;
    status_word[adc_fifo_pkg::STAT_HALF_N_BIT] = !at_half;
  end

  // Control register write
  always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      control_q <= adc_fifo_pkg::CONTROL_RESET;
    end else if (REG_WR && hit(REG_ADDR, adc_fifo_pkg::OFS_CONTROL)) begin
      control_q <= REG_WDATA;
    end
  end

  // Interrupt mask write
  always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_mask_q <= adc_fifo_pkg::IRQ_MASK_RESET;
    end else if (REG_WR && hit(REG_ADDR, adc_fifo_pkg::OFS_IRQ_MASK)) begin
      irq_mask_q <= REG_WDATA[IW-1:0];
    end
  end

  // Interrupt events: push, half crossing, overflow drop
  always_comb begin
    irq_set = '0;
    irq_set[adc_fifo_pkg::IRQ_PUSH_BIT] = push && !full;
    irq_set[adc_fifo_pkg::IRQ_HALF_BIT] = at_half && !half_prev_q;
    irq_set[adc_fifo_pkg::IRQ_OVERFLOW_BIT] = push && full;
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_stat_q <= '0;
      half_prev_q <= 1'b0;
    end else begin
      half_prev_q <= at_half;
      if (REG_WR && hit(REG_ADDR, adc_fifo_pkg::OFS_IRQ_STATUS)) begin
        irq_stat_q <= (irq_stat_q & ~REG_WDATA[IW-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_q <= 1'b0;
      present_n_q <= 1'b0;
      half_n_q <= 1'b1;
    end else begin
      irq_q <= |((irq_stat_q | irq_set) & irq_mask_q);
      present_n_q <= !empty;
      half_n_q <= !at_half;
    end
  end

  // Read data one cycle after the strobe; empty pop gives stale head
  always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        adc_fifo_pkg::OFS_RESULT_POP: rdata_q <= fmt_result;
        adc_fifo_pkg::OFS_STATUS: rdata_q <= status_word;
        adc_fifo_pkg::OFS_CONTROL: rdata_q <= control_q;
        adc_fifo_pkg::OFS_IRQ_STATUS: rdata_q <= {{(W-IW){1'b0}}, irq_stat_q};
        adc_fifo_pkg::OFS_IRQ_MASK: rdata_q <= {{(W-IW){1'b0}}, irq_mask_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign REG_RDATA = rdata_q;
  assign IRQ = irq_q;
  assign RESULTS_PRESENT_N = present_n_q;
  assign HALF_CAPACITY_N = half_n_q;

  // Assertions
  // Push adds exactly one entry
  AST_PUSH_GROWS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (push && !full && !pop) |=> (count == $past(count) + 1'b1))
    else $error("push did not grow occupancy");
  // Push and pop together keep the count
  AST_PUSH_POP_BOTH: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (push && pop && !full && !empty) |=> (count == $past(count)))
    else $error("push with pop changed occupancy");
  // Read pops one entry
  AST_POP_SHRINKS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (pop && !empty && !push) |=> (count == $past(count) - 1'b1))
    else $error("read did not pop");
  // Reading an empty store moves nothing
  AST_EMPTY_POP_SAFE: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (pop && empty && !push) |=> (count == '0))
    else $error("empty read changed occupancy");
  // Ghost conversions leave the store alone
  AST_GHOST_NO_PUSH: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (CONV_DONE && DISCARD_RESULT_FLAG && !pop) |=> (count == $past(count)))
    else $error("ghost conversion was stored");
  // Full store flags and drops the new result
  AST_FULL_DROPS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (full && push && !pop) |=> (full && irq_stat_q[adc_fifo_pkg::IRQ_OVERFLOW_BIT]))
    else $error("full fifo accepted data");
  // Dropped result leaves the count unchanged
  AST_OVERFLOW_KEEPS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (full && push && !pop) |=> (count == $past(count)))
    else $error("overflow changed occupancy");
  // Occupancy never exceeds the depth
  AST_COUNT_BOUND: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (count <= CW'(DEPTH)))
    else $error("occupancy above depth");

  // Writes to the result register are ignored
  AST_RESULT_READ_ONLY: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (REG_WR && !REG_RD && (REG_ADDR == adc_fifo_pkg::OFS_RESULT_POP) && !push)
    |=> (count == $past(count)))
    else $error("write to result register changed occupancy");
  // Only the result offset pops
  AST_POP_DECODE: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (REG_RD && (REG_ADDR != adc_fifo_pkg::OFS_RESULT_POP) && !push)
    |=> (count == $past(count)))
    else $error("other read popped the store");
  // Oldest entry stays at the head until read
  AST_HEAD_STABLE: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (!pop && !empty) |=> $stable(head_data))
    else $error("head entry changed without a read");
  // First result into an empty store becomes the head
  AST_FIRST_PUSH_HEAD: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (push && empty) |=> (head_data == $past(CONV_DATA)))
    else $error("first result not at head");

  // Present flag follows occupancy
  AST_PRESENT_FLAG: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    ##1 (RESULTS_PRESENT_N == ($past(count) != '0)))
    else $error("present flag wrong");
  // Status present bit follows occupancy
  AST_PRESENT_STATUS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (REG_RD && (REG_ADDR == adc_fifo_pkg::OFS_STATUS))
    |=> (REG_RDATA[adc_fifo_pkg::STAT_PRESENT_N_BIT] == ($past(count) != '0)))
    else $error("status present bit wrong");
  // Half flag follows occupancy
  AST_HALF_FLAG: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    ##1 (HALF_CAPACITY_N == ($past(count) < CW'(DEPTH / 2))))
    else $error("half flag wrong");
  // Status half bit follows occupancy
  AST_HALF_STATUS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (REG_RD && (REG_ADDR == adc_fifo_pkg::OFS_STATUS))
    |=> (REG_RDATA[adc_fifo_pkg::STAT_HALF_N_BIT] == ($past(count) < CW'(DEPTH / 2))))
    else $error("status half bit wrong");

  // Straight binary image
  AST_UNIPOLAR_FMT: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (pop && !empty && !control_q[adc_fifo_pkg::CTRL_POLARITY_BIT])
    |=> (REG_RDATA == {4'h0, $past(head_data)}))
    else $error("straight binary format wrong");
  // Two's complement upper bits
  AST_BIPOLAR_FMT: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (pop && !empty && control_q[adc_fifo_pkg::CTRL_POLARITY_BIT])
    |=> (REG_RDATA[15:11] == {5{~$past(head_data[11])}}))
    else $error("two's complement format wrong");
  // Two's complement low bits pass through
  AST_BIPOLAR_LOW: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (pop && !empty && control_q[adc_fifo_pkg::CTRL_POLARITY_BIT])
    |=> (REG_RDATA[10:0] == $past(head_data[10:0])))
    else $error("two's complement low bits wrong");
  // Upper nibble chosen by the polarity bit
  AST_FORMAT_SELECT: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (pop && !empty)
    |=> (REG_RDATA[15:12] ==
      ($past(control_q[adc_fifo_pkg::CTRL_POLARITY_BIT]) ? {4{~$past(head_data[11])}} : 4'h0)))
    else $error("format selection wrong");
  // Control word changes only on a write
  AST_CONTROL_HOLD: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    !(REG_WR && (REG_ADDR == adc_fifo_pkg::OFS_CONTROL)) |=> $stable(control_q))
    else $error("control word changed without a write");
  // Read data returns to zero when idle
  AST_RDATA_IDLE: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    !REG_RD |=> (REG_RDATA == '0))
    else $error("read data not cleared");

  // Events always land in the sticky bits
  AST_EVENT_STICKS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (irq_set != '0) |=> ((irq_stat_q & $past(irq_set)) == $past(irq_set)))
    else $error("event lost from status");
  // Sticky bits clear only by a status write
  AST_STATUS_HOLDS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    !(REG_WR && (REG_ADDR == adc_fifo_pkg::OFS_IRQ_STATUS))
    |=> ((irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q)))
    else $error("status bit cleared without a write");
  // Unmasked sticky bit raises the line
  AST_IRQ_RAISE: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    ((irq_stat_q & irq_mask_q) != '0) |=> IRQ)
    else $error("interrupt line not raised");
  // Nothing unmasked keeps the line low
  AST_IRQ_QUIET: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_q)
    (((irq_stat_q | irq_set) & irq_mask_q) == '0) |=> !IRQ)
    else $error("interrupt line raised without cause");
endmodule : adc_result_fifo_readout
`default_nettype wire

// ---- adc_result_fifo_readout_tb.sv ----
// Self-checking bench for the conversion-result FIFO readout
`timescale 1ns/1ps
`default_nettype none
module adc_result_fifo_readout_tb;
  localparam int DEPTH = 4;
  logic clk_sys, arst_n, reg_wr, reg_rd, conv_done, discard, irq, present_n, half_n;
  logic req, ghost, g;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [11:0] conv_data, val, v;
  logic [11:0] q[$];
  logic [11:0] corner[4] = '{12'h000, 12'h7ff, 12'h800, 12'hfff};
  int fail_count, checks_done;
  adc_result_fifo_readout #(.DEPTH(DEPTH)) DUT (.CLK_SYS(clk_sys), .ARST_N(arst_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
    .DISCARD_RESULT_FLAG(discard), .IRQ(irq), .RESULTS_PRESENT_N(present_n),
    .HALF_CAPACITY_N(half_n));
  adc_conv_model conv (.clk(clk_sys), .rst_n(arst_n), .req(req), .val(val), .ghost(ghost),
    .done(conv_done), .data(conv_data), .discard(discard));
  // Clock, 100 ns period
  always #50 clk_sys = ~clk_sys;
  // Expected register image of a result
  function automatic logic [15:0] fmt(input logic [11:0] x, input logic p);
    fmt = p ? {{5{~x[11]}}, x[10:0]} : {4'h0, x};
  endfunction : fmt
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] r);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd
  // Flags against the model occupancy
  task automatic flags();
    check(16'(present_n), 16'(q.size() != 0));
    check(16'(half_n), 16'(q.size() < DEPTH / 2));
  endtask : flags
  task automatic push(input logic [11:0] x, input logic gh);
    @(posedge clk_sys);
    req <= 1'b1;
    val <= x;
    ghost <= gh;
    @(posedge clk_sys);
    req <= 1'b0;
    if (!gh && q.size() < DEPTH) q.push_back(x);
    repeat (3) @(posedge clk_sys);
    #1 flags();
  endtask : push
  // Host drains after checking the status register each time
  task automatic drain(input logic p);
    while (q.size() > 0) begin
      rd(adc_fifo_pkg::OFS_STATUS, d);
      check(d, {14'h0, q.size() < DEPTH / 2, 1'b1});
      rd(adc_fifo_pkg::OFS_RESULT_POP, d);
      check(d, fmt(q.pop_front(), p));
    end
    repeat (3) @(posedge clk_sys);
    #1 flags();
  endtask : drain
  // Watchdog
  initial begin
    #2000000;
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    {clk_sys, arst_n, reg_wr, reg_rd, req, ghost} = '0;
    {reg_addr, reg_wdata, val} = '0;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(98));
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(adc_fifo_pkg::OFS_CONTROL, d);
    check(d, adc_fifo_pkg::CONTROL_RESET);
    rd(adc_fifo_pkg::OFS_IRQ_MASK, d);
    check(d & 16'h0007, {13'h0, adc_fifo_pkg::IRQ_MASK_RESET});
    rd(8'h40, d);
    check(d, 16'h0000);
    wr(adc_fifo_pkg::OFS_RESULT_POP, 16'h0abc);
    repeat (3) @(posedge clk_sys);
    #1 flags();
    // Corner values in both formats, then random traffic with ghosts
    for (int r = 0; r < 8; r++) begin
      wr(adc_fifo_pkg::OFS_CONTROL, {15'h0, r[0]});
      rd(adc_fifo_pkg::OFS_CONTROL, d);
      check(d, {15'h0, r[0]});
      for (int k = 0; k < 4; k++) begin
        v = (r < 2) ? corner[k] : 12'($urandom);
        g = (r >= 2) && ($urandom % 3 == 0);
        push(v, g);
      end
      drain(r[0]);
    end
    // Overflow drops the extra result and keeps the stored ones
    wr(adc_fifo_pkg::OFS_IRQ_STATUS, 16'h0007);
    wr(adc_fifo_pkg::OFS_CONTROL, 16'h0000);
    for (int k = 0; k < 5; k++) push(corner[k % 4] ^ 12'h0a5, 1'b0);
    rd(adc_fifo_pkg::OFS_IRQ_STATUS, d);
    check(d, 16'h0007);
    drain(1'b0);
    // Interrupt raised, cleared and masked
    wr(adc_fifo_pkg::OFS_IRQ_STATUS, 16'h0007);
    wr(adc_fifo_pkg::OFS_IRQ_MASK, 16'h0001);
    push(12'h321, 1'b0);
    check(16'(irq), 16'h0001);
    wr(adc_fifo_pkg::OFS_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1 check(16'(irq), 16'h0000);
    wr(adc_fifo_pkg::OFS_IRQ_MASK, 16'h0000);
    push(12'h654, 1'b0);
    check(16'(irq), 16'h0000);
    rd(adc_fifo_pkg::OFS_IRQ_STATUS, d);
    check(d, 16'h0003);
    drain(1'b0);
    results();
  end
endmodule : adc_result_fifo_readout_tb
`default_nettype wire
